/* core/cfg_loader_consts.svh */
// Constants for the configuration loader control block.
// Included by the package and the loader; definitions only.
`ifndef CFG_LOADER_CONSTS_SVH
`define CFG_LOADER_CONSTS_SVH
`define ADDR_W          16
`define DATA_W          8
`define REV_W           2
`define ADDR_ZERO       16'h0000
`define TERMINAL_COUNT  16'hffff
`define CLK_PERIOD_PS   5000
`define DELAY_MIN_US    500
`define DELAY_SER_MAX_US 3000
`define DELAY_PAR_MAX_US 30000
`define DELAY_CYCLES    ((`DELAY_MIN_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DLY_W           24
`endif

/* core/cfg_loader_ctrl.sv */
// Reset, standby and address control of a configuration memory.
// Assumes pins are asynchronous; reset line is open drain with external pull-up.
//
// Contract
// - Drive the reset line low while power is coming up.
// - After supplies are good, hold reset low a further release delay.
// - Release delay lies within 0.5 to 3 ms serial, 0.5 to 30 ms parallel.
// - Core supply below power-down threshold re-resets until power good again.
// - Reset line is always active low, never invertible.
// - Reset line low or chip select high clears address, cascade high, outputs float.
// - Serial variant releases on core supply alone.
// - Parallel variant also needs the output supply good.
// - Chip select high is standby regardless of the reset line.
// - Serial: increment below terminal count; at it hold, float data, cascade low.
// - Terminal count is the highest address; the address holds there, never wrapping to zero.
// - Parallel: stop at end address with cascade high, at terminal with cascade low.
// - End address is the last address of the selected revision.
// - Busy stalls address with outputs driven, only in parallel uncompressed mode.
// - With revisions, address reset loads the selected bank start.
// - Without revisions, address reset loads zero; forwarded clock floats in reset.
// - Config pulse rising edge samples the revision from pins or internal bits.
`default_nettype none
`include "cfg_loader_consts.svh"
module cfg_loader_ctrl (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_core_supply_good,
    input  wire logic                 i_output_supply_good,
    input  wire logic                 i_parallel_variant,
    input  wire logic                 i_parallel_mode,
    input  wire logic                 i_decompress_en,
    input  wire logic                 i_revision_en,
    input  wire logic                 i_rev_from_pins,
    input  wire cfg_loader_pkg::rev_t i_revision_select_pins,
    input  wire cfg_loader_pkg::rev_t i_rev_internal,
    input  wire cfg_loader_pkg::addr_t i_bank_start [4],
    input  wire cfg_loader_pkg::addr_t i_bank_end   [4],
    input  wire logic                 i_reset_oe_in,
    input  wire logic                 i_chip_select_n,
    input  wire logic                 i_config_pulse_line,
    input  wire logic                 i_busy,
    input  wire logic                 i_cfg_clk,
    input  wire cfg_loader_pkg::data_t i_mem_data,
    output logic                      o_reset_oe_n_o,
    output logic                      o_reset_oe_n_oe,
    output cfg_loader_pkg::addr_t     o_mem_addr,
    output cfg_loader_pkg::data_t     o_data,
    output logic                      o_data_oe,
    output logic                      o_forwarded_clock,
    output logic                      o_forwarded_clock_oe,
    output logic                      o_cascade_enable_out_n,
    output cfg_loader_pkg::rev_t      o_revision
);
    import cfg_loader_pkg::*;

    // Two-stage synchronisers for every pin input
    localparam int NS = 9;
    // Config pulse idles high; its stages start high so reset shows no false rise
    localparam logic [NS-1:0] SYNC_RST = 9'h010;
    logic [NS-1:0] raw_w;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    assign raw_w = {i_core_supply_good, i_output_supply_good, i_reset_oe_in,
                    i_chip_select_n, i_config_pulse_line, i_busy, i_cfg_clk,
                    i_revision_select_pins};
    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_sync
            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    s1_r[g] <= SYNC_RST[g];
                    s2_r[g] <= SYNC_RST[g];
                end else begin
                    s1_r[g] <= raw_w[g];
                    s2_r[g] <= s1_r[g];
                end
            end
        end
    endgenerate

    wire core_ok_w  = s2_r[8];
    wire out_ok_w   = s2_r[7];
    wire line_hi_w  = s2_r[6];
    wire cs_n_w     = s2_r[5];
    wire cfp_w      = s2_r[4];
    wire busy_pin_w = s2_r[3];
    wire cclk_w     = s2_r[2];
    wire rev_t rev_pins_w = s2_r[1:0];

    // Edge detectors read only the second stage
    logic cfp_d_r;
    logic cclk_d_r;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfp_d_r  <= 1'b1;
            cclk_d_r <= 1'b0;
        end else begin
            cfp_d_r  <= cfp_w;
            cclk_d_r <= cclk_w;
        end
    end
    wire cfp_rise_w  = cfp_w & ~cfp_d_r;
    wire cclk_rise_w = cclk_w & ~cclk_d_r;

    // Power sequencing; release uses the minimum delay, within every variant's window
    // serial needs core only
    wire pwr_good_w = core_ok_w & (~i_parallel_variant | out_ok_w);
    pwr_state_t pstate_r;
    pwr_state_t pstate_nxt;
    logic [`DLY_W-1:0] dly_r;
    logic [`DLY_W-1:0] dly_nxt;
    localparam logic [`DLY_W-1:0] DLY_LAST = `DLY_W'(`DELAY_CYCLES - 1);
    always_comb begin
        pstate_nxt = pstate_r;
        dly_nxt    = dly_r;
        case (pstate_r)
            ST_POWER_UP: begin
                dly_nxt = '0;
                if (pwr_good_w) begin
                    pstate_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                dly_nxt = dly_r + 1'b1;
                if (dly_r == DLY_LAST) begin
                    pstate_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                dly_nxt = '0;
            end
            default: pstate_nxt = ST_POWER_UP;
        endcase
        if (!pwr_good_w) begin
            pstate_nxt = ST_POWER_UP;
            dly_nxt    = '0;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pstate_r <= ST_POWER_UP;
            dly_r    <= '0;
        end else begin
            pstate_r <= pstate_nxt;
            dly_r    <= dly_nxt;
        end
    end

    // Revision sample and address sequencing
    // busy only in parallel uncompressed output
    wire busy_w     = i_parallel_variant & i_parallel_mode & ~i_decompress_en & busy_pin_w;
    // reset from line or chip select
    wire in_reset_w = cs_n_w | ~line_hi_w | (pstate_r != ST_RUN);
    wire par_w      = i_parallel_variant;
    // Parallel variant needs config pulse high to count
    wire run_w      = ~in_reset_w & (~par_w | cfp_w);
    rev_t rev_r;
    // sample revision choice on config pulse rise
    wire rev_t rev_pick_w = i_rev_from_pins ? rev_pins_w : i_rev_internal;
    wire rev_t rev_now_w  = cfp_rise_w ? rev_pick_w : rev_r;
    wire rev_ena_w       = par_w & i_revision_en;
    wire addr_t start_w  = rev_ena_w ? i_bank_start[rev_now_w] : `ADDR_ZERO;
    wire addr_t end_w    = i_bank_end[rev_r];
    addr_t addr_r;
    addr_t addr_nxt;
    wire at_tc_w = (addr_r == `TERMINAL_COUNT);
    wire at_ea_w = rev_ena_w & (addr_r == end_w) & ~at_tc_w;
    wire step_w  = run_w & cclk_rise_w & ~busy_w & ~at_tc_w & ~at_ea_w;
    wire pulse_rst_w = par_w & ~in_reset_w & cfp_rise_w;
    assign addr_nxt = (in_reset_w | pulse_rst_w) ? start_w :
                      step_w ? addr_r + 1'b1 : addr_r;

    // Output drive decisions
    wire drive_w  = ~in_reset_w & (busy_w | pulse_rst_w | (run_w & ~at_tc_w & ~at_ea_w));
    wire ceo_lo_w = ~in_reset_w & run_w & at_tc_w & ~busy_w & ~pulse_rst_w;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rev_r                  <= '0;
            addr_r                 <= '0;
            o_reset_oe_n_o         <= 1'b0;
            o_reset_oe_n_oe        <= 1'b1;
            o_mem_addr             <= '0;
            o_data                 <= '0;
            o_data_oe              <= 1'b0;
            o_forwarded_clock      <= 1'b0;
            o_forwarded_clock_oe   <= 1'b0;
            o_cascade_enable_out_n <= 1'b1;
            o_revision             <= '0;
        end else begin
            rev_r      <= cfp_rise_w ? rev_pick_w : rev_r;
            addr_r     <= addr_nxt;
            o_mem_addr <= addr_nxt;
            o_revision <= rev_now_w;
            o_reset_oe_n_o  <= 1'b0;
            o_reset_oe_n_oe <= (pstate_nxt != ST_RUN);
            // Busy keeps the current value held and driven
            o_data    <= busy_w ? o_data : i_mem_data;
            o_data_oe <= drive_w;
            o_forwarded_clock    <= busy_w ? o_forwarded_clock : cclk_w;
            o_forwarded_clock_oe <= par_w & drive_w;
            o_cascade_enable_out_n <= ~ceo_lo_w;
        end
    end

    // line held for full delay after power good
    property p_release_delay;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        $fell(o_reset_oe_n_oe) |-> ($past(dly_r) == DLY_LAST);
    endproperty
    a_release_delay: assert property (p_release_delay) else $error("line released early");

    property p_power_drop;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !pwr_good_w |=> o_reset_oe_n_oe;
    endproperty
    a_power_drop: assert property (p_power_drop) else $error("no reset on supply loss");

    property p_par_supply;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (par_w && !out_ok_w) |=> o_reset_oe_n_oe;
    endproperty
    a_par_supply: assert property (p_par_supply) else $error("released without output supply");

    property p_reset_outs;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        in_reset_w |=> (o_cascade_enable_out_n && !o_data_oe && !o_forwarded_clock_oe);
    endproperty
    a_reset_outs: assert property (p_reset_outs) else $error("outputs active in reset");

    property p_standby;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        cs_n_w |=> (addr_r == $past(start_w));
    endproperty
    a_standby: assert property (p_standby) else $error("address not held in standby");

    // cascade low only at terminal count
    property p_ceo_tc;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !o_cascade_enable_out_n |-> $past(at_tc_w) && !o_data_oe;
    endproperty
    a_ceo_tc: assert property (p_ceo_tc) else $error("cascade low off terminal");

    sequence s_busy_run;
        busy_w && !in_reset_w && !cfp_rise_w;
    endsequence
    property p_busy_hold;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_busy_run |=> $stable(addr_r) && o_data_oe;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("address moved under busy");

    // end address holds with cascade high
    property p_end_addr;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (at_ea_w && run_w && !cfp_rise_w) |=> $stable(addr_r) && o_cascade_enable_out_n;
    endproperty
    a_end_addr: assert property (p_end_addr) else $error("end address not held");

    property p_rev_sample;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        cfp_rise_w |=> (rev_r == $past(rev_pick_w));
    endproperty
    a_rev_sample: assert property (p_rev_sample) else $error("revision not sampled");

    property p_pulse_reset;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        pulse_rst_w |=> (addr_r == $past(start_w)) && o_data_oe;
    endproperty
    a_pulse_reset: assert property (p_pulse_reset) else $error("no pulse reset");

    // each accepted clock edge steps once
    sequence s_count;
        step_w && !pulse_rst_w;
    endsequence
    property p_count;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        s_count |=> (addr_r == $past(addr_r) + 1'b1);
    endproperty
    a_count: assert property (p_count) else $error("step missed");

    property p_tc_hold;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (at_tc_w && !in_reset_w && !pulse_rst_w) |=> (addr_r == `TERMINAL_COUNT);
    endproperty
    a_tc_hold: assert property (p_tc_hold) else $error("terminal not held");
endmodule
`default_nettype wire

/* core/cfg_loader_pkg.sv */
// Types for the configuration loader control block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "cfg_loader_consts.svh"
package cfg_loader_pkg;
    typedef enum logic [1:0] {ST_POWER_UP, ST_DELAY, ST_RUN} pwr_state_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef logic [`REV_W-1:0]  rev_t;
endpackage
`default_nettype wire

/* testbench/cfg_loader_ctrl_tb.sv */
// Self-checking bench for the loader control block.
// Assumes the release delay is the minimum count of core cycles.
`default_nettype none
`include "cfg_loader_consts.svh"
module cfg_loader_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfg_loader_pkg::*;
    logic  core_clk, sys_rst, core_good, out_good, cs_n, cf, busy;
    logic  rev_en, rev_pins_sel, run, hold_low, par_var, decomp;
    logic  rst_o, rst_oe, data_oe, fwd, fwd_oe, casc_n, cfg_clk, line;
    rev_t  rev_pins, rev_int, rev;
    addr_t bank_start [4];
    addr_t bank_end [4];
    addr_t addr;
    data_t mem_data, data;
    int    mismatches, comparisons;

    cfg_target_model i_cfg_target_model (.i_run(run), .i_hold_low(hold_low),
        .i_pull_o(rst_o), .i_pull_oe(rst_oe), .i_addr(addr), .o_cfg_clk(cfg_clk),
        .o_line(line), .o_mem_data(mem_data));
    cfg_loader_ctrl i_cfg_loader_ctrl (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
        .i_core_supply_good(core_good), .i_output_supply_good(out_good),
        .i_parallel_variant(par_var), .i_parallel_mode(1'b1), .i_decompress_en(decomp),
        .i_revision_en(rev_en), .i_rev_from_pins(rev_pins_sel),
        .i_revision_select_pins(rev_pins), .i_rev_internal(rev_int),
        .i_bank_start(bank_start), .i_bank_end(bank_end), .i_reset_oe_in(line),
        .i_chip_select_n(cs_n), .i_config_pulse_line(cf), .i_busy(busy),
        .i_cfg_clk(cfg_clk), .i_mem_data(mem_data), .o_reset_oe_n_o(rst_o),
        .o_reset_oe_n_oe(rst_oe), .o_mem_addr(addr), .o_data(data), .o_data_oe(data_oe),
        .o_forwarded_clock(fwd), .o_forwarded_clock_oe(fwd_oe),
        .o_cascade_enable_out_n(casc_n), .o_revision(rev));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Whole link clock periods, then the clock stands still again
    task automatic steps(input int n);
        @(posedge core_clk) run <= 1'b1;
        repeat (n) @(posedge cfg_clk);
        @(posedge core_clk) run <= 1'b0;
        cycles(8);
    endtask
    task automatic pulse_cf;
        @(posedge core_clk) cf <= 1'b0;
        cycles(8);
        cf <= 1'b1;
        cycles(8);
    endtask
    task automatic t_power_up;
        int cnt;
        cnt = 0;
        check("pull_at_power_up", rst_oe, 1);
        core_good <= 1'b1;
        cycles(200);
        check("pull_no_output_supply", rst_oe, 1);
        // Serial variant may release without the output supply
        par_var <= 1'b0;
        while (rst_oe === 1'b1 && cnt < `DELAY_CYCLES + 100) begin
            @(posedge core_clk);
            cnt++;
        end
        check("release_not_early", cnt >= `DELAY_CYCLES, 1);
        check("release_not_late", cnt <= `DELAY_CYCLES + 10, 1);
        check("line_released_high", line, 1);
        check("pull_level_low", rst_o, 0);
        // Output supply settles before the parallel variant looks at it
        out_good <= 1'b1;
        cycles(4);
        par_var <= 1'b1;
        cycles(8);
        check("parallel_kept_released", rst_oe, 0);
    endtask
    task automatic t_standby;
        steps(3);
        check("standby_addr", addr, 0);
        check("standby_cascade", casc_n, 1);
        check("standby_data_oe", data_oe, 0);
        check("standby_fwd_oe", fwd_oe, 0);
    endtask
    task automatic t_stream;
        @(posedge core_clk) cs_n <= 1'b0;
        steps(5);
        check("stream_addr", addr, 5);
        check("stream_data", data, 8'h05 ^ 8'ha5);
        check("stream_data_oe", data_oe, 1);
        check("stream_cascade", casc_n, 1);
        busy <= 1'b1;
        cycles(4);
        @(posedge core_clk) run <= 1'b1;
        @(posedge cfg_clk);
        cycles(5);
        check("busy_fwd_held", fwd, 0);
        steps(2);
        check("busy_addr", addr, 5);
        check("busy_data_oe", data_oe, 1);
        check("busy_fwd_oe", fwd_oe, 1);
        // Busy counts for nothing once decompression is on
        decomp <= 1'b1;
        steps(1);
        check("busy_ignored_addr", addr, 6);
        {busy, decomp} <= 2'h0;
        pulse_cf();
        check("cf_addr_zero", addr, 0);
        steps(2);
        check("restart_addr", addr, 2);
        hold_low <= 1'b1;
        cycles(8);
        check("line_low_addr", addr, 0);
        check("line_low_data_oe", data_oe, 0);
        hold_low <= 1'b0;
        cycles(8);
    endtask
    task automatic t_revisions;
        rev_en <= 1'b1;
        rev_pins_sel <= 1'b1;
        rev_pins <= 2'h2;
        pulse_cf();
        check("rev_from_pins", rev, 2);
        check("rev_bank_start", addr, 16'h0100);
        steps(5);
        check("end_addr_hold", addr, 16'h0102);
        check("end_addr_cascade", casc_n, 1);
        check("end_addr_fwd_oe", fwd_oe, 0);
        check("end_addr_data_oe", data_oe, 0);
        rev_pins_sel <= 1'b0;
        pulse_cf();
        check("rev_internal", rev, 3);
        steps(4);
        check("terminal_hold", addr, `TERMINAL_COUNT);
        check("terminal_cascade", casc_n, 0);
        check("terminal_data_oe", data_oe, 0);
    endtask
    task automatic t_power_down;
        core_good <= 1'b0;
        cycles(8);
        check("power_down_cascade", casc_n, 1);
        cycles(300);
        check("power_down_pull", rst_oe, 1);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Release delay dominates the run; the limit sits a fifth beyond it
    initial begin
        #600_000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {sys_rst, cs_n, cf, par_var} = 4'hf;
        {core_good, out_good, busy, rev_en, rev_pins_sel, run, hold_low, decomp} = 8'h00;
        {rev_pins, rev_int} = {2'h0, 2'h3};
        bank_start = '{16'h0000, 16'h0040, 16'h0100, 16'hfffd};
        bank_end = '{16'h003f, 16'h00ff, 16'h0102, `TERMINAL_COUNT};
        {mismatches, comparisons} = '0;
        cycles(8);
        sys_rst <= 1'b0;
        cycles(4);
        t_power_up();
        t_standby();
        t_stream();
        t_revisions();
        t_power_down();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* testbench/cfg_target_model.sv */
// Far side of the loader: target configuration port, pulled-up reset line, array data.
// Assumes the loader drives the reset line open drain through an output enable.
`default_nettype none
module cfg_target_model
    import cfg_loader_pkg::*;
(
    input  wire logic   i_run,
    input  wire logic   i_hold_low,
    input  wire logic   i_pull_o,
    input  wire logic   i_pull_oe,
    input  wire addr_t  i_addr,
    output var logic    o_cfg_clk,
    output logic        o_line,
    output data_t       o_mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up wins when released
    assign o_line = (i_pull_oe ? i_pull_o : 1'b1) & ~i_hold_low;
    // Array contents derived from address so a wrong address shows
    assign o_mem_data = i_addr[7:0] ^ 8'ha5;
    // Clock stands low outside frames, as standby wants
    initial begin
        o_cfg_clk = 1'b0;
        forever begin
            #32;
            o_cfg_clk = i_run ? ~o_cfg_clk : 1'b0;
        end
    end
endmodule
`default_nettype wire
